// ==== hdl/txsel_cfg.svh ====
// Register map, field positions, reset values and timing of the crossbar select
// Overview of operation
// [R1] Fast enable low turns fast channels off into standby; high makes them active.
// [R2] Fast mode 00 quad, 01 dual, 10 single.
// [R3] Writing 11 to fast mode keeps the previously held mode.
// [R4] Quad: select bits 1:0 pick source A-D, all four channels to outputs.
// [R5] Dual: bits 2:1 source, bit 0 pair; even to outputs 1:0, odd 3:2.
// [R6] Single: four-bit select picks one of sixteen channels for the output.
// [R7] Side enable low disconnects all side lines; high connects the selection.
// [R8] Side mode 00 quad, 01 dual, 10 single, as for the fast path.
// [R9] Writing 11 to side mode keeps the previously held side mode.
// [R10] Side quad: bits 1:0 pick source, its four signals to the common lines.
// [R11] Side dual: bit 2 pairs A/C or B/D; A/B to lines 1:0, C/D 3:2.
// [R12] Side single: four-bit select picks one of sixteen side signals.
// [R13] Termination bit low disconnects inputs; high connects, subject to pulsing.
// [R14] Channels with pulse bit set lose termination 100 ms on each source change.
// [R15] Termination control register resets to 0x01.
// [R16] Legal writes update routing right after the write, no further command.
`ifndef TXSEL_CFG_SVH
`define TXSEL_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TXSEL_ADDR_FAST 8'h00
`define TXSEL_ADDR_SIDE 8'h01
`define TXSEL_ADDR_TERM 8'h10
`define TXSEL_ADDR_PULSE_AB 8'h11
`define TXSEL_ADDR_PULSE_CD 8'h12

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TXSEL_BIT_EN 6
`define TXSEL_MODE_HI 5
`define TXSEL_MODE_LO 4
`define TXSEL_SEL_HI 3
`define TXSEL_SEL_LO 0
`define TXSEL_BIT_TERM 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TXSEL_RST_EN 1'h1
`define TXSEL_RST_SEL 4'h0
`define TXSEL_RST_TERM 1'h1
`define TXSEL_RST_PULSE 8'h00
`define TXSEL_READ_ZERO 8'h00
`define TXSEL_ILLEGAL_MODE 2'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TXSEL_CLK_MHZ 200
`define TXSEL_PULSE_MS 100
`define TXSEL_PULSE_CYCLES 25'(`TXSEL_PULSE_MS * 1000 * `TXSEL_CLK_MHZ)
`define TXSEL_TIMER_W 25

`endif

// ==== hdl/txsel_pkg.sv ====
// Types shared by the crossbar select design
package txsel_pkg;

	// Bundling modes; code 2'b11 never gets stored
	typedef enum logic [1:0] {
		TXSEL_QUAD = 2'b00,
		TXSEL_DUAL = 2'b01,
		TXSEL_SINGLE = 2'b10
	} txsel_mode_t;

	// One register access from the control host
	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} txsel_reg_req_t;

endpackage : txsel_pkg

// ==== hdl/txsel_pulse_timer.sv ====
// Retriggerable one-shot that holds busy for a set number of cycles
`timescale 1ns/1ps
`default_nettype none
`include "txsel_cfg.svh"

module txsel_pulse_timer #(
	parameter logic [`TXSEL_TIMER_W-1:0] CYCLES = `TXSEL_PULSE_CYCLES
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic start_in,
	output logic busy_out
);
	logic [`TXSEL_TIMER_W-1:0] count_reg;

	// Reload on every start so a new change restarts the full period
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			count_reg <= '0;
		end else if (start_in) begin
			count_reg <= CYCLES;
		end else if (count_reg != '0) begin
			count_reg <= count_reg - 1'b1;
		end
	end

	assign busy_out = (count_reg != '0);

endmodule : txsel_pulse_timer
`default_nettype wire

// ==== hdl/txsel_crossbar.sv ====
// Configuration registers and select decoding of the source crossbar
`timescale 1ns/1ps
`default_nettype none
`include "txsel_cfg.svh"

module txsel_crossbar #(
	parameter logic [`TXSEL_TIMER_W-1:0] PULSE_CYCLES = `TXSEL_PULSE_CYCLES
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire txsel_pkg::txsel_reg_req_t reg_req_in,
	output logic [7:0] rd_data_out,
	input wire logic [15:0] fast_in,
	output logic [3:0] fast_out,
	output logic fast_active_out,
	input wire logic [15:0] side_in,
	output logic [3:0] side_common_lines_out,
	output logic side_connect_out,
	output logic [15:0] term_connect_out
);
	import txsel_pkg::*;

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic fast_path_enable_reg;
	txsel_mode_t fast_bundling_mode_reg;
	logic [3:0] fast_source_select_reg;
	logic side_path_enable_reg;
	txsel_mode_t side_bundling_mode_reg;
	logic [3:0] side_source_select_reg;
	logic input_termination_on_reg;
	logic [15:0] termination_pulse_select_reg;
	logic [1:0] wr_mode;
	logic fast_wr;
	logic side_wr;
	logic route_change;
	logic pulse_busy;
	logic [15:0] fast_meta_reg;
	logic [15:0] fast_sync_reg;
	logic [15:0] side_meta_reg;
	logic [15:0] side_sync_reg;
	logic [15:0] pulse_by_chan;
	logic [3:0] fast_next;
	logic [3:0] side_next;
	logic [7:0] rd_next;

	assign wr_mode = reg_req_in.wdata[`TXSEL_MODE_HI:`TXSEL_MODE_LO];
	assign fast_wr = reg_req_in.wr_en &&
		(reg_req_in.addr == `TXSEL_ADDR_FAST);
	assign side_wr = reg_req_in.wr_en &&
		(reg_req_in.addr == `TXSEL_ADDR_SIDE);

	// Fast path mode register; an illegal mode leaves the old mode in place
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			fast_path_enable_reg <= `TXSEL_RST_EN;
			fast_bundling_mode_reg <= TXSEL_QUAD;
			fast_source_select_reg <= `TXSEL_RST_SEL;
		end else if (fast_wr) begin
			fast_path_enable_reg <= reg_req_in.wdata[`TXSEL_BIT_EN]; // R16
			fast_source_select_reg <=
				reg_req_in.wdata[`TXSEL_SEL_HI:`TXSEL_SEL_LO];
			if (wr_mode != `TXSEL_ILLEGAL_MODE) begin // R3
				fast_bundling_mode_reg <= txsel_mode_t'(wr_mode);
			end
		end
	end

	// Side path mode register; same retention of the old mode
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			side_path_enable_reg <= `TXSEL_RST_EN;
			side_bundling_mode_reg <= TXSEL_QUAD;
			side_source_select_reg <= `TXSEL_RST_SEL;
		end else if (side_wr) begin
			side_path_enable_reg <= reg_req_in.wdata[`TXSEL_BIT_EN];
			side_source_select_reg <=
				reg_req_in.wdata[`TXSEL_SEL_HI:`TXSEL_SEL_LO];
			if (wr_mode != `TXSEL_ILLEGAL_MODE) begin // R9
				side_bundling_mode_reg <= txsel_mode_t'(wr_mode);
			end
		end
	end

	// Termination and pulse-select registers
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			input_termination_on_reg <= `TXSEL_RST_TERM; // R15
			termination_pulse_select_reg <= {`TXSEL_RST_PULSE,
				`TXSEL_RST_PULSE};
		end else if (reg_req_in.wr_en) begin
			unique case (reg_req_in.addr)
				`TXSEL_ADDR_TERM: begin
					input_termination_on_reg <=
						reg_req_in.wdata[`TXSEL_BIT_TERM];
				end
				`TXSEL_ADDR_PULSE_AB: begin
					termination_pulse_select_reg[7:0] <= reg_req_in.wdata;
				end
				`TXSEL_ADDR_PULSE_CD: begin
					termination_pulse_select_reg[15:8] <= reg_req_in.wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Register read-back
	// ----------------------------------------------------------------
	// Unmapped addresses and reserved bits read as zero
	always_comb begin
		rd_next = `TXSEL_READ_ZERO;
		unique case (reg_req_in.addr)
			`TXSEL_ADDR_FAST: begin
				rd_next[`TXSEL_BIT_EN] = fast_path_enable_reg;
				rd_next[`TXSEL_MODE_HI:`TXSEL_MODE_LO] = fast_bundling_mode_reg;
				rd_next[`TXSEL_SEL_HI:`TXSEL_SEL_LO] = fast_source_select_reg;
			end
			`TXSEL_ADDR_SIDE: begin
				rd_next[`TXSEL_BIT_EN] = side_path_enable_reg;
				rd_next[`TXSEL_MODE_HI:`TXSEL_MODE_LO] = side_bundling_mode_reg;
				rd_next[`TXSEL_SEL_HI:`TXSEL_SEL_LO] = side_source_select_reg;
			end
			`TXSEL_ADDR_TERM: begin
				rd_next[`TXSEL_BIT_TERM] = input_termination_on_reg;
			end
			`TXSEL_ADDR_PULSE_AB: begin
				rd_next = termination_pulse_select_reg[7:0];
			end
			`TXSEL_ADDR_PULSE_CD: begin
				rd_next = termination_pulse_select_reg[15:8];
			end
			default: begin
			end
		endcase
	end

	// Read data is captured on a read strobe and held until the next one
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rd_data_out <= `TXSEL_READ_ZERO;
		end else if (reg_req_in.rd_en) begin
			rd_data_out <= rd_next;
		end
	end

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			fast_meta_reg <= '0;
			fast_sync_reg <= '0;
			side_meta_reg <= '0;
			side_sync_reg <= '0;
		end else begin
			fast_meta_reg <= fast_in;
			fast_sync_reg <= fast_meta_reg;
			side_meta_reg <= side_in;
			side_sync_reg <= side_meta_reg;
		end
	end

	// ----------------------------------------------------------------
	// Select decoding, one output line per loop pass
	// ----------------------------------------------------------------
	// Input index is source * 4 + channel
	function automatic logic [3:0] fast_index(input txsel_mode_t mode,
		input logic [3:0] sel, input logic [1:0] line);
		logic [3:0] idx;
		idx = sel;
		unique case (mode)
			TXSEL_QUAD: idx = {sel[1:0], line}; // R4
			TXSEL_DUAL: idx = {sel[2:1], sel[0], line[1]}; // R5
			TXSEL_SINGLE: idx = sel; // R6
			default: idx = sel;
		endcase
		return idx;
	endfunction : fast_index

	// Side dual pairs A with C or B with D, line 3:2 taking the upper source
	function automatic logic [3:0] side_index(input txsel_mode_t mode,
		input logic [3:0] sel, input logic [1:0] line);
		logic [3:0] idx;
		idx = sel;
		unique case (mode)
			TXSEL_QUAD: idx = {sel[1:0], line}; // R10
			TXSEL_DUAL: idx = {line[1], sel[2], sel[1:0]}; // R11
			TXSEL_SINGLE: idx = sel; // R12
			default: idx = sel;
		endcase
		return idx;
	endfunction : side_index

	generate
		for (genvar o = 0; o < 4; o++) begin : g_line
			localparam logic [1:0] LINE = 2'(o);
			// Disabled paths drive their lines low
			assign fast_next[o] = fast_path_enable_reg && // R1
				fast_sync_reg[fast_index(fast_bundling_mode_reg, // R2
				fast_source_select_reg, LINE)];
			assign side_next[o] = side_path_enable_reg && // R7
				side_sync_reg[side_index(side_bundling_mode_reg, // R8
				side_source_select_reg, LINE)];
		end
	endgenerate

	// Routed data leave through flip-flops
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			fast_out <= '0;
			side_common_lines_out <= '0;
		end else begin
			fast_out <= fast_next;
			side_common_lines_out <= side_next;
		end
	end

	assign fast_active_out = fast_path_enable_reg; // R1
	assign side_connect_out = side_path_enable_reg; // R7

	// ----------------------------------------------------------------
	// Input termination with pulse on source change
	// ----------------------------------------------------------------
	// A fast write that changes the stored select or mode counts as a switch
	assign route_change = fast_wr && ((reg_req_in.wdata[`TXSEL_SEL_HI:
		`TXSEL_SEL_LO] != fast_source_select_reg) ||
		((wr_mode != `TXSEL_ILLEGAL_MODE) &&
		(wr_mode != fast_bundling_mode_reg)));

	txsel_pulse_timer #(
		.CYCLES(PULSE_CYCLES)
	) u_pulse_timer (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.start_in(route_change),
		.busy_out(pulse_busy)
	);

	// Pulse bits 0-7 are B0-B3, A0-A3; bits 8-15 are C3-C0, D3-D0
	generate
		for (genvar c = 0; c < 4; c++) begin : g_pulse_map
			assign pulse_by_chan[c] = termination_pulse_select_reg[4 + c];
			assign pulse_by_chan[4 + c] = termination_pulse_select_reg[c];
			assign pulse_by_chan[8 + c] = termination_pulse_select_reg[11 - c];
			assign pulse_by_chan[12 + c] = termination_pulse_select_reg[15 - c];
		end
	endgenerate

	// Termination held open while the pulse runs on selected channels
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			term_connect_out <= '1;
		end else begin
			term_connect_out <= {16{input_termination_on_reg}} & // R13
				~(pulse_by_chan & {16{pulse_busy}}); // R14
		end
	end

endmodule : txsel_crossbar
`default_nettype wire

// ==== testbench/txsel_crossbar_checker.sv ====
// Concurrent checks on the crossbar select ports
`timescale 1ns/1ps
`default_nettype none

module txsel_crossbar_checker (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire txsel_pkg::txsel_reg_req_t reg_req_in,
	input wire logic [7:0] rd_data_out,
	input wire logic [3:0] fast_out,
	input wire logic fast_active_out,
	input wire logic [3:0] side_common_lines_out,
	input wire logic side_connect_out,
	input wire logic [15:0] term_connect_out
);
	import txsel_pkg::*;
	logic [7:0] since_wr_reg;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// Cycles since the last write that may drop terminations
	always_ff @(posedge clk_in) begin
		if (rst_in)
			since_wr_reg <= 8'hff;
		else if (reg_req_in.wr_en && (reg_req_in.addr == 8'h00
			|| reg_req_in.addr == 8'h10 || reg_req_in.addr == 8'h11
			|| reg_req_in.addr == 8'h12))
			since_wr_reg <= 8'h00;
		else if (since_wr_reg != 8'hff)
			since_wr_reg <= since_wr_reg + 8'h01;
	end
	// Write of termination off, then two cycles to take effect
	sequence s_term_off_wr;
		reg_req_in.wr_en && reg_req_in.addr == 8'h10 && !reg_req_in.wdata[0];
	endsequence
	sequence s_all_open;
		##2 term_connect_out == 16'h0000;
	endsequence
	a_fast_standby_zero: assert property (
		!fast_active_out && $past(!fast_active_out) |-> fast_out == 4'h0)
		else $error("fast lines driven in standby");
	a_side_off_zero: assert property (
		!side_connect_out && $past(!side_connect_out)
		|-> side_common_lines_out == 4'h0)
		else $error("side lines driven while switched off");
	a_fast_en_write: assert property (
		reg_req_in.wr_en && reg_req_in.addr == 8'h00
		|=> fast_active_out == $past(reg_req_in.wdata[6]))
		else $error("fast enable did not follow write");
	a_side_en_write: assert property (
		reg_req_in.wr_en && reg_req_in.addr == 8'h01
		|=> side_connect_out == $past(reg_req_in.wdata[6]))
		else $error("side enable did not follow write");
	a_term_off_all: assert property (s_term_off_wr |-> s_all_open)
		else $error("terminations still connected after off write");
	a_term_drop_cause: assert property (
		|($past(term_connect_out) & ~term_connect_out)
		|-> since_wr_reg <= 8'h04)
		else $error("termination dropped without a write");
	a_term_read_zero: assert property (
		reg_req_in.rd_en && reg_req_in.addr == 8'h10
		|=> rd_data_out[7:1] == 7'h00)
		else $error("termination register upper bits not zero");
	a_reset_state: assert property (
		$fell(rst_in) |-> term_connect_out == 16'hffff
		&& fast_active_out && side_connect_out && fast_out == 4'h0)
		else $error("outputs wrong after reset");
endmodule : txsel_crossbar_checker

bind txsel_crossbar txsel_crossbar_checker u_chk (
	.clk_in(clk_in),
	.rst_in(rst_in),
	.reg_req_in(reg_req_in),
	.rd_data_out(rd_data_out),
	.fast_out(fast_out),
	.fast_active_out(fast_active_out),
	.side_common_lines_out(side_common_lines_out),
	.side_connect_out(side_connect_out),
	.term_connect_out(term_connect_out)
);
`default_nettype wire

// ==== testbench/txsel_host_model.sv ====
// Control host model issuing register writes and reads
`timescale 1ns/1ps
`default_nettype none

module txsel_host_model (
	input wire logic clk_in,
	input wire logic [7:0] rd_data_in,
	output var txsel_pkg::txsel_reg_req_t req_out
);
	import txsel_pkg::*;
	// Idle request so nothing is taken during reset
	initial begin
		req_out = '0;
	end
	// One write strobe, raised and dropped at falling edges
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_in);
		req_out = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
		@(negedge clk_in);
		req_out = '0;
	endtask : write
	// One read strobe; data is registered on the edge that takes it and sampled half a cycle later
	task automatic read(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_in);
		req_out = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
		@(negedge clk_in);
		d = rd_data_in;
		req_out = '0;
	endtask : read
endmodule : txsel_host_model
`default_nettype wire

// ==== testbench/tb_txsel_crossbar.sv ====
// Self-checking testbench of the crossbar select block
`timescale 1ns/1ps
`default_nettype none

module tb_txsel_crossbar;
	import txsel_pkg::*;
	localparam int PULSE = 16;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [15:0] fast_in = 16'h0000;
	logic [15:0] side_in = 16'h0000;
	txsel_reg_req_t req;
	logic [7:0] rd_data, d;
	logic [3:0] fast_out, side_lines;
	logic fast_active, side_connect;
	logic [15:0] term;
	int fails = 0;
	int total_checks = 0;
	logic [7:0] r_addr [6] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h05};
	logic [7:0] r_val [6] = '{8'h40, 8'h40, 8'h01, 8'h00, 8'h00, 8'h00};
	logic [15:0] pat [4] = '{16'h00ff, 16'h0f0f, 16'h3333, 16'h5555};

	// ----------------------------------------------------------------
	// Clock, host model and device
	// ----------------------------------------------------------------
	always #2.5 clk_in = ~clk_in;
	txsel_host_model u_host (.clk_in(clk_in), .rd_data_in(rd_data),
		.req_out(req));
	txsel_crossbar #(.PULSE_CYCLES(25'(PULSE))) u_dut (.clk_in(clk_in),
		.rst_in(rst_in), .reg_req_in(req), .rd_data_out(rd_data),
		.fast_in(fast_in), .fast_out(fast_out),
		.fast_active_out(fast_active), .side_in(side_in),
		.side_common_lines_out(side_lines),
		.side_connect_out(side_connect), .term_connect_out(term));

	// ----------------------------------------------------------------
	// Expected routing and reporting
	// ----------------------------------------------------------------
	function automatic logic [15:0] route(input int m, input int s,
		input logic [15:0] v, input bit side);
		logic [15:0] r;
		int idx;
		r = 16'h0000;
		for (int o = 0; o < 4; o++) begin
			if (m == 0)
				idx = (s % 4) * 4 + o;
			else if (m == 1 && side)
				idx = (o / 2) * 8 + ((s / 4) % 2) * 4 + s % 4;
			else if (m == 1)
				idx = ((s / 2) % 4) * 4 + (s % 2) * 2 + o / 2;
			else
				idx = s;
			r[o] = v[idx];
		end
		return r;
	endfunction : route
	task automatic check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic summarize();
		if (fails == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(negedge clk_in);
		rst_in = 1'b0;
		check("term_reset", term, 16'hffff);
		for (int i = 0; i < 6; i++) begin
			u_host.read(r_addr[i], d);
			check("reset_read", 16'(d), 16'(r_val[i]));
		end
		// Every mode and select code on both paths
		for (int m = 0; m < 3; m++) begin
			for (int s = 0; s < 16; s++) begin
				u_host.write(8'h00, {2'b01, 2'(m), 4'(s)});
				u_host.write(8'h01, {2'b01, 2'(m), 4'(s)});
				for (int p = 0; p < 4; p++) begin
					fast_in = pat[p];
					side_in = ~pat[p];
					repeat (4) @(negedge clk_in);
					check("fast_route", 16'(fast_out), route(m, s, pat[p], 0));
					check("side_route", 16'(side_lines), route(m, s, ~pat[p], 1));
				end
			end
		end
		// Illegal mode code keeps old mode, select still taken
		u_host.write(8'h00, 8'h53);
		u_host.write(8'h00, 8'h75);
		u_host.read(8'h00, d);
		check("fast_mode_kept", 16'(d), 16'h0055);
		u_host.write(8'h01, 8'h53);
		u_host.write(8'h01, 8'h75);
		u_host.read(8'h01, d);
		check("side_mode_kept", 16'(d), 16'h0055);
		// Both paths off, then back on
		u_host.write(8'h00, 8'h00);
		u_host.write(8'h01, 8'h00);
		fast_in = 16'hffff;
		side_in = 16'hffff;
		repeat (4) @(negedge clk_in);
		check("fast_off", {11'h000, fast_active, fast_out}, 16'h0000);
		check("side_off", {11'h000, side_connect, side_lines}, 16'h0000);
		u_host.write(8'h00, 8'h40);
		u_host.write(8'h01, 8'h40);
		repeat (3) @(negedge clk_in);
		check("fast_on", {11'h000, fast_active, fast_out}, 16'h001f);
		check("side_on", {11'h000, side_connect, side_lines}, 16'h001f);
		// Termination off and on
		u_host.write(8'h10, 8'h00);
		repeat (2) @(negedge clk_in);
		check("term_off", term, 16'h0000);
		u_host.write(8'h10, 8'h01);
		repeat (2) @(negedge clk_in);
		check("term_on", term, 16'hffff);
		// Pulse on B0 and C3 when the source changes
		u_host.write(8'h11, 8'h01);
		u_host.write(8'h12, 8'h01);
		u_host.write(8'h00, 8'h41);
		repeat (3) @(negedge clk_in);
		check("term_pulse", term, 16'hf7ef);
		repeat (PULSE + 4) @(negedge clk_in);
		check("term_pulse_end", term, 16'hffff);
		u_host.read(8'h11, d);
		check("pulse_ab_read", 16'(d), 16'h0001);
		u_host.read(8'h12, d);
		check("pulse_cd_read", 16'(d), 16'h0001);
		summarize();
	end
	// Watchdog reckoned well beyond the thousand or so cycles of the tests
	initial begin
		#100000;
		fails++;
		summarize();
	end
endmodule : tb_txsel_crossbar
`default_nettype wire
